// File: verilog/dtc_pkg.sv
package dtc_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL = 8'h88;
    localparam logic [7:0] IDX_MODE = 8'h89;
    localparam logic [7:0] IDX_LO_A = 8'h8a;
    localparam logic [7:0] IDX_LO_B = 8'h8b;
    localparam logic [7:0] IDX_HI_A = 8'h8c;
    localparam logic [7:0] IDX_HI_B = 8'h8d;
    localparam logic [7:0] IDX_LATCH = 8'hb0;

    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] CNT_RST = 8'h00;
    localparam logic [7:0] LATCH_RST = 8'hff;

    // Control register fields
    localparam int BIT_OVF_B = 7;
    localparam int BIT_RUN_B = 6;
    localparam int BIT_OVF_A = 5;
    localparam int BIT_RUN_A = 4;

    // Mode register fields
    localparam int BIT_GATE_B = 7;
    localparam int BIT_CNT_B = 6;
    localparam int MODE_B_LSB = 4;
    localparam int BIT_GATE_A = 3;
    localparam int BIT_CNT_A = 2;
    localparam int MODE_A_LSB = 0;

    // Port latch bits enabling the alternate pin functions
    localparam int LB_IRQ_A = 2;
    localparam int LB_IRQ_B = 3;
    localparam int LB_CNT_A = 4;
    localparam int LB_CNT_B = 5;

    // Machine cycle of twelve clocks; phase = 2*(state-1)+(p-1)
    localparam logic [3:0] MC_CLKS = 4'hc;
    localparam logic [3:0] PH_LAST = MC_CLKS - 4'h1;
    localparam logic [3:0] PH_SAMPLE = 4'h9;
    localparam logic [3:0] PH_UPDATE = 4'h4;

    typedef enum logic [1:0] {
        MODE_13 = 2'h0,
        MODE_16 = 2'h1,
        MODE_RELOAD = 2'h2,
        MODE_SPLIT = 2'h3
    } dtc_mode_e;

    typedef struct packed {
        logic second_ext_irq_pin;
        logic first_ext_irq_pin;
        logic second_count_input_pin;
        logic first_count_input_pin;
    } dtc_pins_s;

    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
        logic ovf;
    } dtc_cnt_s;

endpackage

// File: verilog/dtc_timers.sv
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps

// Notes on behaviour
// - Two timers, each high and low byte
// - Timer function ticks once per twelve clocks
// - Pin sampled per machine cycle, falling edge counts
// - Edge count shows at update phase next cycle
// - Edge recognition spans two machine cycles
// - Gate bit adds irq pin high condition
// - Function bit picks pin or machine cycles
// - Mode 0: high byte plus 5-bit prescaler
// - Mode 1: cascaded 16-bit counter
// - Mode 2: low byte reloads from high
// - Second timer in mode 3 holds count
// - First timer split; high uses second controls
// - Mode register: second upper, first lower
// - Control low nibble does not affect timers
// - Pin functions need port latch bit set
// - Overflow sets flag; vector acknowledge clears
// - Run bit starts and stops timer
// - Reload leaves high byte unchanged
module dtc_timers #(
    parameter int AW = 10
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire dtc_pkg::dtc_pins_s pins,
    input wire logic first_vector_ack,
    input wire logic second_vector_ack,
    output logic first_timer_overflow_flag,
    output logic second_timer_overflow_flag
);

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    logic [3:0] phase_ff;
    logic [7:0] ctrl_ff;
    logic [7:0] mode_ff;
    logic [7:0] latch_ff;
    logic [7:0] lo_a_ff;
    logic [7:0] hi_a_ff;
    logic [7:0] lo_b_ff;
    logic [7:0] hi_b_ff;
    logic [1:0] smp_ff;
    logic [1:0] fall_ff;
    logic ack_ff;
    logic [31:0] dat_ff;
    logic sample_en;
    logic update_en;
    logic cnt_pin_a;
    logic cnt_pin_b;
    logic irq_pin_a;
    logic irq_pin_b;
    logic run_a;
    logic run_b;
    logic tick_a;
    logic tick_b;
    logic tick_hi_a;
    logic split_a;
    logic [8:0] hi_a_inc;
    dtc_pkg::dtc_mode_e mode_a;
    dtc_pkg::dtc_mode_e mode_b;
    dtc_pkg::dtc_cnt_s res_a;
    dtc_pkg::dtc_cnt_s res_b;
    logic acc;
    logic wr;
    logic [7:0] idx;
    logic [7:0] rd_mux;
    logic wr_ctrl;
    logic wr_lo_a;
    logic wr_hi_a;
    logic wr_lo_b;
    logic wr_hi_b;
    logic set_a;
    logic set_b;

    ////////////////////////////////////////////////////////////////////
    // Counting step for modes 0 to 2; mode 3 counts the low byte alone

    function automatic dtc_pkg::dtc_cnt_s step(
        input dtc_pkg::dtc_mode_e md,
        input logic [7:0] hi,
        input logic [7:0] lo,
        input logic inc
    );
        dtc_pkg::dtc_cnt_s s;
        s.hi = hi;
        s.lo = lo;
        s.ovf = 1'b0;
        if (inc)
        begin
            case (md)
                dtc_pkg::MODE_13:
                    {s.ovf, s.hi, s.lo[4:0]} = {1'b0, hi, lo[4:0]} + 14'h1;
                dtc_pkg::MODE_16:
                    {s.ovf, s.hi, s.lo} = {1'b0, hi, lo} + 17'h1;
                dtc_pkg::MODE_RELOAD:
                begin
                    {s.ovf, s.lo} = {1'b0, lo} + 9'h1;
                    if (s.ovf)
                        s.lo = hi;
                end
                default:
                    {s.ovf, s.lo} = {1'b0, lo} + 9'h1;
            endcase
        end
        return s;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Machine cycle phases

    always_ff @(posedge mclk)
    begin
        if (reset || phase_ff == dtc_pkg::PH_LAST)
            phase_ff <= 4'h0;
        else
            phase_ff <= phase_ff + 4'h1;
    end

    assign sample_en = phase_ff == dtc_pkg::PH_SAMPLE;
    assign update_en = phase_ff == dtc_pkg::PH_UPDATE;

    assign cnt_pin_a = pins.first_count_input_pin
                       & latch_ff[dtc_pkg::LB_CNT_A];
    assign cnt_pin_b = pins.second_count_input_pin
                       & latch_ff[dtc_pkg::LB_CNT_B];
    assign irq_pin_a = pins.first_ext_irq_pin & latch_ff[dtc_pkg::LB_IRQ_A];
    assign irq_pin_b = pins.second_ext_irq_pin
                       & latch_ff[dtc_pkg::LB_IRQ_B];

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            smp_ff <= 2'h0;
            fall_ff <= 2'h0;
        end
        else if (sample_en)
        begin
            smp_ff <= {cnt_pin_b, cnt_pin_a};
            fall_ff <= smp_ff & ~{cnt_pin_b, cnt_pin_a};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Run and tick decisions

    assign mode_a = dtc_pkg::dtc_mode_e'(mode_ff[dtc_pkg::MODE_A_LSB +: 2]);
    assign mode_b = dtc_pkg::dtc_mode_e'(mode_ff[dtc_pkg::MODE_B_LSB +: 2]);
    assign split_a = mode_a == dtc_pkg::MODE_SPLIT;

    assign run_a = ctrl_ff[dtc_pkg::BIT_RUN_A]
                   & (~mode_ff[dtc_pkg::BIT_GATE_A] | irq_pin_a);
    assign run_b = ctrl_ff[dtc_pkg::BIT_RUN_B]
                   & (~mode_ff[dtc_pkg::BIT_GATE_B] | irq_pin_b);

    assign tick_a = update_en & run_a
                    & (~mode_ff[dtc_pkg::BIT_CNT_A] | fall_ff[0]);
    assign tick_b = update_en & run_b
                    & (~mode_ff[dtc_pkg::BIT_CNT_B] | fall_ff[1])
                    & (mode_b != dtc_pkg::MODE_SPLIT);
    assign tick_hi_a = update_en & split_a & ctrl_ff[dtc_pkg::BIT_RUN_B];
    assign hi_a_inc = {1'b0, hi_a_ff} + {8'h0, tick_hi_a};

    assign res_a = step(mode_a, hi_a_ff, lo_a_ff, tick_a);
    assign res_b = step(mode_b, hi_b_ff, lo_b_ff, tick_b);

    // Second timer loses its flag while the first is split
    assign set_a = res_a.ovf;
    assign set_b = split_a ? hi_a_inc[8] : res_b.ovf;

    ////////////////////////////////////////////////////////////////////
    // Wishbone slave: one wait state, unmapped reads give zero

    assign acc = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign wr = acc & wb_we_i & wb_sel_i[0];
    assign idx = wb_adr_i[9:2];
    assign wr_ctrl = wr && idx == dtc_pkg::IDX_CTRL;
    assign wr_lo_a = wr && idx == dtc_pkg::IDX_LO_A;
    assign wr_hi_a = wr && idx == dtc_pkg::IDX_HI_A;
    assign wr_lo_b = wr && idx == dtc_pkg::IDX_LO_B;
    assign wr_hi_b = wr && idx == dtc_pkg::IDX_HI_B;

    always_comb
    begin
        case (idx)
            dtc_pkg::IDX_CTRL: rd_mux = ctrl_ff;
            dtc_pkg::IDX_MODE: rd_mux = mode_ff;
            dtc_pkg::IDX_LO_A: rd_mux = lo_a_ff;
            dtc_pkg::IDX_LO_B: rd_mux = lo_b_ff;
            dtc_pkg::IDX_HI_A: rd_mux = hi_a_ff;
            dtc_pkg::IDX_HI_B: rd_mux = hi_b_ff;
            dtc_pkg::IDX_LATCH: rd_mux = latch_ff;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0;
        end
        else
        begin
            ack_ff <= acc;
            if (acc)
                dat_ff <= {24'h0, rd_mux};
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;

    ////////////////////////////////////////////////////////////////////
    // Configuration registers

    always_ff @(posedge mclk)
    begin
        if (reset)
            mode_ff <= dtc_pkg::MODE_RST;
        else if (wr && idx == dtc_pkg::IDX_MODE)
            mode_ff <= wb_dat_i[7:0];
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            latch_ff <= dtc_pkg::LATCH_RST;
        else if (wr && idx == dtc_pkg::IDX_LATCH)
            latch_ff <= wb_dat_i[7:0];
    end

    // plain storage bits; flags set over clear
    always_ff @(posedge mclk)
    begin
        if (reset)
            ctrl_ff <= dtc_pkg::CTRL_RST;
        else
        begin
            if (wr_ctrl)
                ctrl_ff <= wb_dat_i[7:0];
            ctrl_ff[dtc_pkg::BIT_OVF_A] <= set_a | (wr_ctrl
                ? wb_dat_i[dtc_pkg::BIT_OVF_A]
                : ctrl_ff[dtc_pkg::BIT_OVF_A] & ~first_vector_ack);
            ctrl_ff[dtc_pkg::BIT_OVF_B] <= set_b | (wr_ctrl
                ? wb_dat_i[dtc_pkg::BIT_OVF_B]
                : ctrl_ff[dtc_pkg::BIT_OVF_B] & ~second_vector_ack);
        end
    end

    assign first_timer_overflow_flag = ctrl_ff[dtc_pkg::BIT_OVF_A];
    assign second_timer_overflow_flag = ctrl_ff[dtc_pkg::BIT_OVF_B];

    ////////////////////////////////////////////////////////////////////
    // Count bytes

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            lo_a_ff <= dtc_pkg::CNT_RST;
            hi_a_ff <= dtc_pkg::CNT_RST;
            lo_b_ff <= dtc_pkg::CNT_RST;
            hi_b_ff <= dtc_pkg::CNT_RST;
        end
        else
        begin
            lo_a_ff <= wr_lo_a ? wb_dat_i[7:0] : res_a.lo;
            lo_b_ff <= wr_lo_b ? wb_dat_i[7:0] : res_b.lo;
            hi_b_ff <= wr_hi_b ? wb_dat_i[7:0] : res_b.hi;
            if (wr_hi_a)
                hi_a_ff <= wb_dat_i[7:0];
            else
                hi_a_ff <= split_a ? hi_a_inc[7:0] : res_a.hi;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_edge_a;
        sample_en && smp_ff[0] && !cnt_pin_a;
    endsequence

    sequence s_count_slot;
        update_en && run_a && mode_ff[dtc_pkg::BIT_CNT_A]
        && mode_a == dtc_pkg::MODE_16 && !wr_lo_a && !wr_hi_a;
    endsequence

    AST_PHASE_WRAP: assert property (phase_ff == dtc_pkg::PH_LAST
        |=> phase_ff == 4'h0 ##4 update_en)
        else $error("machine cycle not twelve clocks");

    AST_TIMER_TICK: assert property (
        update_en && run_a && !mode_ff[dtc_pkg::BIT_CNT_A]
        && mode_a == dtc_pkg::MODE_16 && !wr_lo_a && !wr_hi_a
        |=> {hi_a_ff, lo_a_ff} == $past({hi_a_ff, lo_a_ff}) + 16'h1)
        else $error("timer did not advance by one");

    AST_EDGE_SEEN: assert property (s_edge_a |=> fall_ff[0])
        else $error("falling edge not recorded");

    AST_UPDATE_PHASE: assert property (
        !$stable(lo_a_ff) && !$past(wr_lo_a)
        |-> $past(phase_ff) == dtc_pkg::PH_UPDATE)
        else $error("count changed outside update phase");

    AST_EDGE_LATENCY: assert property (
        s_edge_a ##7 s_count_slot |=> !$stable(lo_a_ff))
        else $error("edge not counted in following cycle");

    AST_GATE_HOLD: assert property (
        mode_ff[dtc_pkg::BIT_GATE_A] && !irq_pin_a && !split_a
        && !wr_lo_a && !wr_hi_a |=> $stable({hi_a_ff, lo_a_ff}))
        else $error("gated timer advanced");

    AST_RUN_HOLD: assert property (
        !ctrl_ff[dtc_pkg::BIT_RUN_B] && !wr_lo_b && !wr_hi_b
        |=> $stable({hi_b_ff, lo_b_ff}))
        else $error("stopped timer advanced");

    AST_MODE3_HOLD: assert property (
        mode_b == dtc_pkg::MODE_SPLIT && !wr_lo_b && !wr_hi_b
        |=> $stable({hi_b_ff, lo_b_ff}))
        else $error("second timer moved in mode 3");

    AST_RELOAD: assert property (
        tick_a && mode_a == dtc_pkg::MODE_RELOAD && lo_a_ff == 8'hff
        && !wr_lo_a && !wr_hi_a
        |=> lo_a_ff == $past(hi_a_ff) && $stable(hi_a_ff)
        && first_timer_overflow_flag)
        else $error("reload wrong");

    AST_SPLIT_HIGH: assert property (
        tick_hi_a && hi_a_ff == 8'hff && !wr_hi_a
        |=> hi_a_ff == 8'h00 && second_timer_overflow_flag)
        else $error("split high byte overflow wrong");

    AST_VECTOR_CLR: assert property (
        first_vector_ack && !set_a && !wr_ctrl
        |=> !first_timer_overflow_flag)
        else $error("flag not cleared on vector");

    AST_LATCH_OFF: assert property (
        sample_en && !latch_ff[dtc_pkg::LB_CNT_A] |=> !smp_ff[0])
        else $error("pin seen with latch bit low");

    AST_WRITE_WINS: assert property (
        wr_lo_a |=> lo_a_ff == $past(wb_dat_i[7:0]))
        else $error("write lost to increment");

    AST_ACK_PULSE: assert property (ack_ff |=> !ack_ff)
        else $error("ack held over two cycles");

endmodule

// File: tb/dtc_pin_model.sv
`timescale 1ns/1ps
// Far side of the port pins: count pins idle high like the pull-ups
module dtc_pin_model (
    input wire logic mclk,
    input wire logic reset,
    input wire logic go,
    input wire logic [3:0] n_pulses,
    input wire logic [1:0] irq_lvl,
    output dtc_pkg::dtc_pins_s pins,
    output logic busy
);
    logic [4:0] tick_ff;
    logic [4:0] left_ff;
    logic cnt_lvl_ff;

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            tick_ff <= 5'h00;
            left_ff <= 5'h00;
            cnt_lvl_ff <= 1'b1;
        end
        else if (go && left_ff == 5'h00)
        begin
            tick_ff <= 5'h00;
            left_ff <= {n_pulses, 1'b0};
        end
        else if (left_ff != 5'h00)
        begin
            tick_ff <= tick_ff + 5'h01;
            if (tick_ff == 5'h0d)
            begin
                tick_ff <= 5'h00;
                left_ff <= left_ff - 5'h01;
                cnt_lvl_ff <= ~cnt_lvl_ff;
            end
        end
    end

    assign busy = left_ff != 5'h00;
    assign pins = dtc_pkg::dtc_pins_s'({irq_lvl, cnt_lvl_ff, cnt_lvl_ff});
endmodule

// File: tb/dual_timer_counter_block_tb.sv
`timescale 1ns/1ps
module dual_timer_counter_block_tb;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [9:0] adr = 10'h000;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic va = 1'b0;
    logic vb = 1'b0;
    logic fa;
    logic fb;
    logic go = 1'b0;
    logic [3:0] np = 4'h0;
    logic [1:0] irq = 2'h3;
    logic busy;
    dtc_pkg::dtc_pins_s pins;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc_cnt = 0;
    logic [7:0] d;

    always #12.5 mclk = ~mclk;

    dtc_timers DUT (.mclk(mclk), .reset(reset), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pins(pins),
        .first_vector_ack(va), .second_vector_ack(vb),
        .first_timer_overflow_flag(fa), .second_timer_overflow_flag(fb));

    dtc_pin_model pm (.mclk(mclk), .reset(reset), .go(go),
        .n_pulses(np), .irq_lvl(irq), .pins(pins), .busy(busy));

    task final_report;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Whole run is well under this; a hang ends here
    always @(posedge mclk)
    begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 30000)
        begin
            n_mismatch++;
            final_report();
        end
    end

    task check(input string name, input logic [7:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Classic cycle: request held until the edge that samples ack
    task bus(input logic w, input logic [7:0] idx, input logic [7:0] v);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hf;
        adr <= {idx, 2'b00};
        wdat <= {24'h0, v};
        do @(posedge mclk); while (ack !== 1'b1);
        d = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task wr(input logic [7:0] idx, input logic [7:0] v);
        bus(1'b1, idx, v);
    endtask

    task rchk(input string name, input logic [7:0] idx, exp);
        bus(1'b0, idx, 8'h00);
        check(name, d, exp);
    endtask

    task wait_flag(input logic b);
        do @(posedge mclk); while ((b ? fb : fa) !== 1'b1);
    endtask

    task vack;
        @(posedge mclk);
        va <= 1'b1;
        vb <= 1'b1;
        @(posedge mclk);
        va <= 1'b0;
        vb <= 1'b0;
        // Let the clear settle before anyone looks at the flags
        @(posedge mclk);
    endtask

    task pulse(input logic [3:0] n);
        @(posedge mclk);
        np <= n;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        do @(posedge mclk); while (busy);
        repeat (30) @(posedge mclk);
    endtask

    // Stop write lands 54 clocks after the wrap: four ticks counted
    task run(input logic t, input logic [1:0] m,
        input logic [7:0] hi, lo, elo, ehi);
        logic [7:0] li;
        logic [7:0] hix;
        li = t ? dtc_pkg::IDX_LO_B : dtc_pkg::IDX_LO_A;
        hix = t ? dtc_pkg::IDX_HI_B : dtc_pkg::IDX_HI_A;
        wr(dtc_pkg::IDX_MODE, t ? {2'h0, m, 4'h0} : {6'h00, m});
        wr(li, lo);
        wr(hix, hi);
        wr(dtc_pkg::IDX_CTRL, t ? 8'h4f : 8'h1f);
        wait_flag(t);
        repeat (51) @(posedge mclk);
        // Writing the flag as one keeps it for the vector clear
        wr(dtc_pkg::IDX_CTRL, t ? 8'h8f : 8'h2f);
        rchk("count low", li, elo);
        rchk("count high", hix, ehi);
        check("flag kept", {7'h00, t ? fb : fa}, 8'h01);
        vack();
        check("flag", {7'h00, t ? fb : fa}, 8'h00);
    endtask

    initial
    begin
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        rchk("ctrl", dtc_pkg::IDX_CTRL, 8'h00);
        rchk("mode", dtc_pkg::IDX_MODE, 8'h00);
        rchk("lo a", dtc_pkg::IDX_LO_A, 8'h00);
        rchk("hi b", dtc_pkg::IDX_HI_B, 8'h00);
        rchk("latch", dtc_pkg::IDX_LATCH, 8'hff);
        rchk("unmapped", 8'h8e, 8'h00);
        for (int t = 0; t < 2; t++)
        begin
            run(t[0], 2'h0, 8'hff, 8'hff, 8'he4, 8'h00);
            run(t[0], 2'h1, 8'hff, 8'hff, 8'h04, 8'h00);
            run(t[0], 2'h2, 8'hf0, 8'hff, 8'hf4, 8'hf0);
        end
        // Write lands on the tick edge itself
        wr(dtc_pkg::IDX_MODE, 8'h01);
        wr(dtc_pkg::IDX_LO_A, 8'hff);
        wr(dtc_pkg::IDX_HI_A, 8'hff);
        wr(dtc_pkg::IDX_CTRL, 8'h10);
        wait_flag(1'b0);
        repeat (9) @(posedge mclk);
        wr(dtc_pkg::IDX_LO_A, 8'h80);
        repeat (39) @(posedge mclk);
        wr(dtc_pkg::IDX_CTRL, 8'h00);
        rchk("write wins", dtc_pkg::IDX_LO_A, 8'h83);
        vack();
        wr(dtc_pkg::IDX_MODE, 8'h33);
        wr(dtc_pkg::IDX_LO_B, 8'h10);
        wr(dtc_pkg::IDX_LO_A, 8'h55);
        wr(dtc_pkg::IDX_HI_A, 8'hff);
        wr(dtc_pkg::IDX_CTRL, 8'h40);
        wait_flag(1'b1);
        repeat (30) @(posedge mclk);
        check("split flag a", {7'h00, fa}, 8'h00);
        check("split flag b", {7'h00, fb}, 8'h01);
        wr(dtc_pkg::IDX_CTRL, 8'h00);
        rchk("split hi a", dtc_pkg::IDX_HI_A, 8'h02);
        rchk("hold b", dtc_pkg::IDX_LO_B, 8'h10);
        rchk("split lo a", dtc_pkg::IDX_LO_A, 8'h55);
        vack();
        wr(dtc_pkg::IDX_MODE, 8'h55);
        wr(dtc_pkg::IDX_LO_A, 8'h00);
        wr(dtc_pkg::IDX_LO_B, 8'h00);
        wr(dtc_pkg::IDX_CTRL, 8'h50);
        pulse(4'h3);
        rchk("events a", dtc_pkg::IDX_LO_A, 8'h03);
        rchk("events b", dtc_pkg::IDX_LO_B, 8'h03);
        // Dropping the latch bits pulls the high pins to 0: one more edge
        wr(dtc_pkg::IDX_LATCH, 8'hcf);
        pulse(4'h2);
        rchk("latched a", dtc_pkg::IDX_LO_A, 8'h04);
        rchk("latched b", dtc_pkg::IDX_LO_B, 8'h04);
        wr(dtc_pkg::IDX_LATCH, 8'hff);
        // Gate closed before the gated timer mode can start counting
        @(posedge mclk);
        irq <= 2'h0;
        wr(dtc_pkg::IDX_MODE, 8'h99);
        wr(dtc_pkg::IDX_LO_A, 8'h00);
        wr(dtc_pkg::IDX_LO_B, 8'h00);
        wr(dtc_pkg::IDX_CTRL, 8'h50);
        repeat (60) @(posedge mclk);
        rchk("gated a", dtc_pkg::IDX_LO_A, 8'h00);
        rchk("gated b", dtc_pkg::IDX_LO_B, 8'h00);
        irq <= 2'h3;
        repeat (60) @(posedge mclk);
        bus(1'b0, dtc_pkg::IDX_LO_A, 8'h00);
        check("open a", {7'h00, d != 8'h00}, 8'h01);
        final_report();
    end
endmodule
